// ### src/occm_map.svh
// register map, field positions, reset values and fixed-point layout of the
// output color correction stage; definitions only, included by bare name
`ifndef OCCM_MAP_SVH
`define OCCM_MAP_SVH

// byte offsets
`define OCCM_CTL_OFFSET      12'h9c0
`define OCCM_STATUS_OFFSET   12'h9c4
`define OCCM_MATRIX_BASE     12'h9d0
`define OCCM_MATRIX_LAST     12'h9fc
`define OCCM_RED_COEF_R      12'h9d0
`define OCCM_RED_COEF_G      12'h9d4
`define OCCM_RED_COEF_B      12'h9d8
`define OCCM_RED_CONST       12'h9dc
`define OCCM_GRN_COEF_R      12'h9e0
`define OCCM_GRN_COEF_G      12'h9e4
`define OCCM_GRN_CONST       12'h9ec
`define OCCM_BLU_COEF_R      12'h9f0
`define OCCM_BLU_COEF_G      12'h9f4
`define OCCM_BLU_COEF_B      12'h9f8
`define OCCM_BLU_CONST       12'h9fc

// field positions
`define OCCM_EN_BIT          0
`define OCCM_COEF_MSB        13
`define OCCM_CONST_MSB       14
`define OCCM_CONST_SLOT      2'h3

// reset values
`define OCCM_CTL_RESET       1'h0
`define OCCM_COEF_RESET      14'h0000
`define OCCM_CONST_RESET     15'h0000

// fixed point: coefficients carry 10 fraction bits, constants 4
`define OCCM_COEF_FRAC       10
`define OCCM_CONST_FRAC      4
`define OCCM_CONST_ALIGN     6

// pixel pipeline depth from input to output, in clock cycles
`define OCCM_LATENCY         2

`endif

// ### src/occm_pkg.sv
// types shared by the output color correction stage
// assumes occm_map.svh for all numeric layout
package occm_pkg;

  typedef logic [7:0]          occm_pix_t;
  typedef logic signed [13:0]  occm_coef_t;
  typedef logic signed [14:0]  occm_const_t;
  typedef logic signed [22:0]  occm_prod_t;
  typedef logic signed [25:0]  occm_sum_t;

endpackage

// ### src/occm_channel.sv
// one output row of the correction matrix: three products, constant, clamp
// assumes coefficients and constant stay stable or are sampled with the pixel
`timescale 1ns/1ps
`include "occm_map.svh"

module occm_channel (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // pixel in
  input  wire occm_pkg::occm_pix_t   pix_r,
  input  wire occm_pkg::occm_pix_t   pix_g,
  input  wire occm_pkg::occm_pix_t   pix_b,
  input  wire occm_pkg::occm_pix_t   raw_pix,
  input  wire logic                  corr_en,
  // row settings
  input  wire occm_pkg::occm_coef_t  coef_r,
  input  wire occm_pkg::occm_coef_t  coef_g,
  input  wire occm_pkg::occm_coef_t  coef_b,
  input  wire occm_pkg::occm_const_t row_offset,
  // result
  output occm_pkg::occm_pix_t        out_pix,
  output logic                       clamped
);

  occm_pkg::occm_prod_t  prod_r_reg;
  occm_pkg::occm_prod_t  prod_g_reg;
  occm_pkg::occm_prod_t  prod_b_reg;
  occm_pkg::occm_const_t offset_reg;
  occm_pkg::occm_pix_t   raw_reg;
  logic                  en_reg;
  occm_pkg::occm_sum_t   sum_next;
  occm_pkg::occm_pix_t   out_next;
  logic                  clamp_next;

  // stage 1: products against the pixel as unsigned, coefficients signed
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prod_r_reg <= '0;
      prod_g_reg <= '0;
      prod_b_reg <= '0;
      offset_reg <= '0;
      raw_reg    <= '0;
      en_reg     <= 1'b0;
    end else begin
      prod_r_reg <= coef_r * $signed({1'b0, pix_r});  // [RULE2] [RULE3] [RULE4] [RULE5]
      prod_g_reg <= coef_g * $signed({1'b0, pix_g});
      prod_b_reg <= coef_b * $signed({1'b0, pix_b});
      offset_reg <= row_offset;
      raw_reg    <= raw_pix;
      en_reg     <= corr_en;
    end
  end

  // constant moved to ten fraction bits so it adds straight onto the products
  always_comb begin
    sum_next = 26'(prod_r_reg) + 26'(prod_g_reg) + 26'(prod_b_reg)
             + 26'($signed({offset_reg, 6'h00}));  // [RULE6] [RULE2] [RULE3] [RULE4]
    clamp_next = 1'b0;
    if (sum_next[25]) begin
      out_next   = 8'h00;  // [RULE8]
      clamp_next = 1'b1;
    end else if (sum_next[24:18] != 7'h00) begin
      out_next   = 8'hff;  // [RULE8]
      clamp_next = 1'b1;
    end else begin
      out_next = sum_next[17:10];
    end
  end

  // stage 2: corrected value or untouched pixel
  always_ff @(posedge clock) begin
    if (!resetn) begin
      out_pix <= '0;
      clamped <= 1'b0;
    end else begin
      out_pix <= en_reg ? out_next : raw_reg;  // [RULE1] [RULE8]
      clamped <= en_reg & clamp_next;
    end
  end

  // independent reference: integer arithmetic straight from the inputs
  int ref_sum;
  int ref_sat;
  always_comb begin
    ref_sum = int'(coef_r) * int'({1'b0, pix_r}) + int'(coef_g) * int'({1'b0, pix_g})
            + int'(coef_b) * int'({1'b0, pix_b}) + int'(row_offset) * 64;
    ref_sat = ref_sum < 0 ? 0 : ((ref_sum >>> 10) > 255 ? 255 : (ref_sum >>> 10));
  end

  chk_row_result: assert property (@(posedge clock) disable iff (!resetn)  // [RULE2] [RULE3] [RULE4]
    corr_en |-> ##2 (int'(out_pix) == $past(ref_sat, 2)))
    else $error("corrected channel value differs from weighted sum");

  chk_clamp_low: assert property (@(posedge clock) disable iff (!resetn)  // [RULE8]
    (corr_en && ref_sum < 0) |-> ##2 (out_pix == 8'h00 && clamped))
    else $error("negative sum not clamped to zero");

endmodule

// ### src/occm_top.sv
// output color correction stage of the display backend: register port plus
// a three-row matrix on the pixel stream from the blender to the timing
// controller; assumes one clock, pixels of 8 bits per component
//
// Notes on behaviour
// RULE1 - correction acts only while control bit 0 is one; zero disables it
// RULE2 - red out is red-row coefficients times red, green, blue plus red constant
// RULE3 - green out is green-row coefficients times inputs plus green constant
// RULE4 - blue out is blue-row coefficients times inputs plus blue constant
// RULE5 - coefficients are 14-bit fields in bits 13:0 with ten fraction bits
// RULE6 - constants are 15-bit fields in bits 14:0 with four fraction bits
// RULE7 - red-row coefficients sit at 0x9d0, 0x9d4, 0x9d8; other rows alike
// RULE8 - disabled passes pixels unchanged; enabled uses signed values, clamps results
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "occm_map.svh"

module occm_top (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               resetn,
  // register port
  input  wire logic [11:0]        reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // pixels from the blender
  input  wire logic               in_valid,
  input  wire occm_pkg::occm_pix_t in_r,
  input  wire occm_pkg::occm_pix_t in_g,
  input  wire occm_pkg::occm_pix_t in_b,
  // pixels toward the timing controller
  output logic                    out_valid,
  output occm_pkg::occm_pix_t     out_r,
  output occm_pkg::occm_pix_t     out_g,
  output occm_pkg::occm_pix_t     out_b
);

  // control and matrix storage
  logic                  color_correct_enable_bit_reg;
  occm_pkg::occm_coef_t  coef_reg  [3][3];
  occm_pkg::occm_const_t const_reg [3];

  // pipeline bookkeeping
  logic [1:0]            valid_pipe_reg;
  logic [1:0]            en_pipe_reg;
  logic [2:0]            clamp_seen;

  // register decode
  logic [11:0]           matrix_off;
  logic                  matrix_hit;
  logic [1:0]            row_sel;
  logic [1:0]            slot_sel;

  occm_pkg::occm_pix_t   pix_in  [3];
  occm_pkg::occm_pix_t   pix_out [3];

  assign pix_in[0] = in_r;
  assign pix_in[1] = in_g;
  assign pix_in[2] = in_b;

  // rows step by 16 bytes, slots by 4; slot 3 of each row is its constant
  assign matrix_off = reg_addr - `OCCM_MATRIX_BASE;
  assign matrix_hit = (reg_addr >= `OCCM_MATRIX_BASE) && (reg_addr <= `OCCM_MATRIX_LAST)
                    && (reg_addr[1:0] == 2'h0);  // [RULE7]
  assign row_sel    = matrix_off[5:4];
  assign slot_sel   = matrix_off[3:2];

  // enable bit; the rest of the control word is ignored on write
  always_ff @(posedge clock) begin
    if (!resetn) begin
      color_correct_enable_bit_reg <= `OCCM_CTL_RESET;
    end else if (reg_wr && reg_addr == `OCCM_CTL_OFFSET) begin
      color_correct_enable_bit_reg <= reg_wdata[`OCCM_EN_BIT];  // [RULE1]
    end
  end

  // one generate loop builds each row's storage and its datapath
  genvar row;
  genvar col;
  generate
    for (row = 0; row < 3; row++) begin : g_row
      for (col = 0; col < 3; col++) begin : g_col
        always_ff @(posedge clock) begin
          if (!resetn) begin
            coef_reg[row][col] <= `OCCM_COEF_RESET;
          end else if (reg_wr && matrix_hit && row_sel == 2'(row)
                       && slot_sel == 2'(col)) begin
            coef_reg[row][col] <= reg_wdata[`OCCM_COEF_MSB:0];  // [RULE5] [RULE7]
          end
        end
      end

      always_ff @(posedge clock) begin
        if (!resetn) begin
          const_reg[row] <= `OCCM_CONST_RESET;
        end else if (reg_wr && matrix_hit && row_sel == 2'(row)
                     && slot_sel == `OCCM_CONST_SLOT) begin
          const_reg[row] <= reg_wdata[`OCCM_CONST_MSB:0];  // [RULE6]
        end
      end

      // the enable travels with each pixel, so a mid-frame write never
      // splits one pixel between corrected and raw components
      occm_channel u_channel (
        .clock      (clock),
        .resetn     (resetn),
        .pix_r      (in_r),
        .pix_g      (in_g),
        .pix_b      (in_b),
        .raw_pix    (pix_in[row]),
        .corr_en    (color_correct_enable_bit_reg),  // [RULE1]
        .coef_r     (coef_reg[row][0]),
        .coef_g     (coef_reg[row][1]),
        .coef_b     (coef_reg[row][2]),
        .row_offset (const_reg[row]),
        .out_pix    (pix_out[row]),
        .clamped    (clamp_seen[row])
      );
    end
  endgenerate

  assign out_r = pix_out[0];  // [RULE2]
  assign out_g = pix_out[1];  // [RULE3]
  assign out_b = pix_out[2];  // [RULE4]

  // valid and enable follow the pixel through both stages
  always_ff @(posedge clock) begin
    if (!resetn) begin
      valid_pipe_reg <= 2'h0;
      en_pipe_reg    <= 2'h0;
    end else begin
      valid_pipe_reg <= {valid_pipe_reg[0], in_valid};
      en_pipe_reg    <= {en_pipe_reg[0], color_correct_enable_bit_reg};
    end
  end

  assign out_valid = valid_pipe_reg[1];

  // read data stand in the cycle after the strobe only, zero otherwise
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_addr == `OCCM_CTL_OFFSET) begin
      reg_rdata <= {31'h0, color_correct_enable_bit_reg};
    end else if (reg_addr == `OCCM_STATUS_OFFSET) begin
      // enable as seen by the pixel leaving now, and the clamps it took
      reg_rdata <= {27'h0, clamp_seen, en_pipe_reg[1], out_valid};
    end else if (matrix_hit && slot_sel == `OCCM_CONST_SLOT) begin
      reg_rdata <= {17'h0, const_reg[row_sel]};  // [RULE6]
    end else if (matrix_hit) begin
      reg_rdata <= {18'h0, coef_reg[row_sel][slot_sel]};  // [RULE5] [RULE7]
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  chk_enable_write: assert property (  // [RULE1]
    (reg_wr && reg_addr == `OCCM_CTL_OFFSET) |=>
      (color_correct_enable_bit_reg == $past(reg_wdata[0])))
    else $error("enable bit did not take written value");

  chk_bypass_pass: assert property (  // [RULE8]
    (in_valid && !color_correct_enable_bit_reg) |-> ##2
      (out_valid && out_r == $past(in_r, 2) && out_g == $past(in_g, 2)
       && out_b == $past(in_b, 2)))
    else $error("disabled stage altered a pixel");

  chk_valid_latency: assert property (  // [RULE1]
    in_valid |-> ##2 out_valid)
    else $error("pixel valid lost in the pipeline");

  chk_no_spurious: assert property (
    !in_valid |-> ##2 !out_valid)
    else $error("output valid without an input pixel");

  chk_coef_field: assert property (  // [RULE5]
    (reg_wr && reg_addr == `OCCM_RED_COEF_G) ##1 (reg_rd && reg_addr == `OCCM_RED_COEF_G
      && !reg_wr) |=> (reg_rdata == {18'h0, $past(reg_wdata[13:0], 2)}))
    else $error("coefficient field not held in bits 13:0");

  chk_const_field: assert property (  // [RULE6]
    (reg_wr && reg_addr == `OCCM_RED_CONST) |=>
      (const_reg[0] == $past(reg_wdata[14:0])))
    else $error("constant field not held in bits 14:0");

  chk_red_slots: assert property (  // [RULE7]
    (reg_rd && reg_addr == `OCCM_RED_COEF_B) |=>
      (reg_rdata == {18'h0, $past(coef_reg[0][2])}))
    else $error("red-row blue coefficient not at its slot");

  chk_red_first: assert property (  // [RULE7]
    (reg_wr && reg_addr == `OCCM_RED_COEF_R) |=>
      (coef_reg[0][0] == $past(reg_wdata[13:0]) && coef_reg[1][0] == $past(coef_reg[1][0])))
    else $error("red-row red coefficient misplaced");

  chk_unmapped_zero: assert property (
    (reg_rd && !matrix_hit && reg_addr != `OCCM_CTL_OFFSET
     && reg_addr != `OCCM_STATUS_OFFSET) |=> (reg_rdata == 32'h0))
    else $error("unmapped read returned nonzero data");

  chk_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == 32'h0))
    else $error("read data present without a read strobe");

  chk_clamp_gate: assert property (  // [RULE8]
    (in_valid && !color_correct_enable_bit_reg) |-> ##2 (clamp_seen == 3'h0))
    else $error("clamp reported while correction disabled");

  // each matrix word but the red-row and green-row blue coefficients and the red constant lands in its own row and slot and leaves a neighbour alone;
  // a decode slip by one row would otherwise only show as subtly wrong colours
  chk_red_green: assert property (  // [RULE7]
    (reg_wr && reg_addr == `OCCM_RED_COEF_G) |=>
      (coef_reg[0][1] == $past(reg_wdata[`OCCM_COEF_MSB:0]) && $stable(coef_reg[1][1])))
    else $error("red-row green coefficient misplaced");

  chk_green_first: assert property (  // [RULE7]
    (reg_wr && reg_addr == `OCCM_GRN_COEF_R) |=>
      (coef_reg[1][0] == $past(reg_wdata[`OCCM_COEF_MSB:0]) && $stable(coef_reg[0][0])))
    else $error("green-row red coefficient misplaced");

  chk_green_mid: assert property (  // [RULE7]
    (reg_wr && reg_addr == `OCCM_GRN_COEF_G) |=>
      (coef_reg[1][1] == $past(reg_wdata[`OCCM_COEF_MSB:0]) && $stable(coef_reg[2][1])))
    else $error("green-row green coefficient misplaced");

  chk_blue_first: assert property (  // [RULE7]
    (reg_wr && reg_addr == `OCCM_BLU_COEF_R) |=>
      (coef_reg[2][0] == $past(reg_wdata[`OCCM_COEF_MSB:0]) && $stable(coef_reg[1][0])))
    else $error("blue-row red coefficient misplaced");

  chk_blue_mid: assert property (  // [RULE7]
    (reg_wr && reg_addr == `OCCM_BLU_COEF_G) |=>
      (coef_reg[2][1] == $past(reg_wdata[`OCCM_COEF_MSB:0]) && $stable(coef_reg[0][1])))
    else $error("blue-row green coefficient misplaced");

  chk_blue_last: assert property (  // [RULE7]
    (reg_wr && reg_addr == `OCCM_BLU_COEF_B) |=>
      (coef_reg[2][2] == $past(reg_wdata[`OCCM_COEF_MSB:0]) && $stable(coef_reg[1][2])))
    else $error("blue-row blue coefficient misplaced");

  chk_green_const: assert property (  // [RULE6]
    (reg_wr && reg_addr == `OCCM_GRN_CONST) |=>
      (const_reg[1] == $past(reg_wdata[`OCCM_CONST_MSB:0]) && $stable(const_reg[0])))
    else $error("green constant misplaced");

  chk_blue_const: assert property (  // [RULE6]
    (reg_wr && reg_addr == `OCCM_BLU_CONST) |=>
      (const_reg[2] == $past(reg_wdata[`OCCM_CONST_MSB:0]) && $stable(const_reg[1])))
    else $error("blue constant misplaced");

  chk_misaligned_write: assert property (  // [RULE7]
    (reg_wr && reg_addr[1:0] != 2'h0) |=>
      ($stable(coef_reg[0][0]) && $stable(const_reg[2])
       && $stable(color_correct_enable_bit_reg)))
    else $error("misaligned write changed a register");

  chk_enable_hold: assert property (  // [RULE1]
    !(reg_wr && reg_addr == `OCCM_CTL_OFFSET) |=> $stable(color_correct_enable_bit_reg))
    else $error("enable bit changed without a control write");

  chk_const_hold: assert property (  // [RULE6]
    !reg_wr |=> ($stable(const_reg[0]) && $stable(const_reg[1]) && $stable(const_reg[2])))
    else $error("constant changed without a write");

  chk_ctl_readback: assert property (  // [RULE1]
    (reg_rd && reg_addr == `OCCM_CTL_OFFSET) |=>
      (reg_rdata == {31'h0, $past(color_correct_enable_bit_reg)}))
    else $error("control read does not show the enable bit");

  // status describes the pixel leaving at the read edge; nothing in it is sticky,
  // so software polling it sees a snapshot, not a history
  chk_status_valid: assert property (
    (reg_rd && reg_addr == `OCCM_STATUS_OFFSET) |=>
      (reg_rdata[0] == $past(in_valid, 3)))
    else $error("status valid bit not aligned with the leaving pixel");

  chk_status_enable: assert property (  // [RULE1]
    (reg_rd && reg_addr == `OCCM_STATUS_OFFSET) |=>
      (reg_rdata[1] == $past(color_correct_enable_bit_reg, 3)))
    else $error("status enable bit not aligned with the leaving pixel");

  chk_status_upper: assert property (
    (reg_rd && reg_addr == `OCCM_STATUS_OFFSET) |=>
      (reg_rdata[31:5] == 27'h0))
    else $error("status upper bits not zero");

  // a clamp flag may only stand beside a component pinned to one end of its range
  chk_clamp_red: assert property (  // [RULE8]
    clamp_seen[0] |-> (out_r == 8'h00 || out_r == 8'hff))
    else $error("red clamp flagged on a value inside the range");

  chk_clamp_green: assert property (  // [RULE8]
    clamp_seen[1] |-> (out_g == 8'h00 || out_g == 8'hff))
    else $error("green clamp flagged on a value inside the range");

  chk_clamp_blue: assert property (  // [RULE8]
    clamp_seen[2] |-> (out_b == 8'h00 || out_b == 8'hff))
    else $error("blue clamp flagged on a value inside the range");

endmodule

// ### testbench/occm_blender_model.sv
// pixel source standing in for the blender ahead of the correction stage
// assumes the stage never pushes back; one pixel per clock at most
`timescale 1ns/1ps

module occm_blender_model (
  // pixels toward the stage
  output logic                in_valid,
  output occm_pkg::occm_pix_t in_r,
  output occm_pkg::occm_pix_t in_g,
  output occm_pkg::occm_pix_t in_b
);
  initial begin
    in_valid = 1'b0;
    in_r     = 8'h00;
    in_g     = 8'h00;
    in_b     = 8'h00;
  end

  // called just after a rising edge; idle cycles invert the data so a
  // stage that samples without valid cannot pass by luck
  task automatic put(input logic v, input logic [7:0] r, g, b);
    in_valid <= v;
    in_r     <= v ? r : ~in_r;
    in_g     <= v ? g : ~in_g;
    in_b     <= v ? b : ~in_b;
  endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the output color correction stage
// assumes src/ compiled first; the status word is read once, in a known state
`timescale 1ns/1ps

module testbench;
  logic                clock = 1'b0;
  logic                resetn = 1'b0;
  logic [11:0]         reg_addr = 12'h000;
  logic [31:0]         reg_wdata = 32'h0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [31:0]         reg_rdata;
  logic                in_valid, out_valid;
  occm_pkg::occm_pix_t in_r, in_g, in_b, out_r, out_g, out_b;
  logic [31:0]         raw [13];
  logic [31:0]         rq[$];
  logic [31:0]         pq[$];
  logic [11:0]         holes [4] = '{12'h9cc, 12'h9d2, 12'ha00, 12'h9fe};
  logic                rd_d = 1'b0, v1 = 1'b0, v2 = 1'b0, seen_rst = 1'b0;
  int                  fails = 0, comparisons = 0, cycles = 0;

  occm_blender_model occm_blender_model_i (.in_valid(in_valid), .in_r(in_r), .in_g(in_g),
    .in_b(in_b));
  occm_top occm_top_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_r(in_r), .in_g(in_g), .in_b(in_b), .out_valid(out_valid),
    .out_r(out_r), .out_g(out_g), .out_b(out_b));

  initial begin
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic int reg_index(input logic [11:0] a);
    if (a == 12'h9c0) return 0;
    if (a >= 12'h9d0 && a <= 12'h9fc && a[1:0] == 2'h0) return 1 + int'((a - 12'h9d0) >> 2);
    return -1;
  endfunction

  function automatic logic [11:0] addr_of(input int i);
    return (i == 0) ? 12'h9c0 : 12'h9d0 + 12'((i - 1) * 4);
  endfunction

  function automatic int cf(input int j);
    return int'($signed(raw[j][13:0]));
  endfunction

  // floor of the weighted sum, then clamp, row by row from red to blue
  function automatic logic [31:0] expect_pix(input logic [7:0] r, g, b);
    int s;
    logic [31:0] res;
    res = 32'h0;
    if (raw[0][0] !== 1'b1) return {8'h00, r, g, b};
    for (int i = 0; i < 3; i++) begin
      s = cf(1 + 4 * i) * int'(r) + cf(2 + 4 * i) * int'(g) + cf(3 + 4 * i) * int'(b);
      s = (s + 64 * int'($signed(raw[4 + 4 * i][14:0]))) >>> 10;
      s = (s < 0) ? 0 : ((s > 255) ? 255 : s);
      res = (res << 8) | 32'(s);
    end
    return res;
  endfunction

  // full-scale ends show up one time in four to hit the clamps
  function automatic logic [7:0] rpix;
    if ($urandom % 4 == 0) return ($urandom % 2) ? 8'hff : 8'h00;
    return 8'($urandom);
  endfunction

  // one clock of stimulus: optional register access beside an optional pixel;
  // a pixel sees the control value from before a write in the same cycle
  task automatic step(input logic w, rr, input logic [11:0] a, input logic [31:0] d,
                      input logic pv);
    logic [7:0] r, g, b;
    int i;
    r = rpix();
    g = rpix();
    b = rpix();
    i = reg_index(a);
    if (pv) pq.push_back(expect_pix(r, g, b));
    occm_blender_model_i.put(pv, r, g, b);
    reg_wr <= w;
    reg_rd <= rr;
    reg_addr <= a;
    reg_wdata <= d;
    if (rr) rq.push_back((i < 0) ? 32'h0 : raw[i]);
    if (w && i >= 0) raw[i] = d & ((i == 0) ? 32'h1 : ((i % 4 == 0) ? 32'h7fff : 32'h3fff));
    @(posedge clock);
  endtask

  always @(posedge clock) begin
    seen_rst <= seen_rst | !resetn;
    rd_d <= reg_rd;
    v1 <= in_valid;
    v2 <= v1;
    if (seen_rst) begin
      check(reg_rdata, rd_d ? (rq.size() ? rq.pop_front() : 'x) : 32'h0, "read data");
      check(32'(out_valid), 32'(v2), "pixel valid");
      if (out_valid === 1'b1)
        check(32'({out_r, out_g, out_b}), pq.size() ? pq.pop_front() : 'x, "pixel");
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'h8c4299bb));
    foreach (raw[i]) raw[i] = 32'h0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    // reset values, field widths and the unmapped holes
    for (int i = 0; i < 13; i++) step(0, 1, addr_of(i), 32'h0, 0);
    for (int i = 0; i < 13; i++) begin
      step(1, 0, addr_of(i), 32'hffffffff, 0);
      step(0, 1, addr_of(i), 32'h0, 0);
    end
    foreach (holes[k]) begin
      step(1, 0, holes[k], $urandom, 0);
      step(0, 1, holes[k], 32'h0, 0);
    end
    // every weight and constant is -1 and the stage is on, so all rows clamp low:
    // status shows three clamps and the enable, with no pixel leaving
    step(0, 1, 12'h9c4, 32'h0, 0);
    rq[rq.size() - 1] = 32'h0000_001e;
    for (int i = 0; i < 13; i++) step(0, 1, addr_of(i), 32'h0, 0);
    $display("test registers done");
    // disabled: pixels pass untouched while reads run beside them
    step(1, 0, 12'h9c0, 32'hfffffffe, 0);
    for (int k = 0; k < 40; k++) step(0, 1, addr_of(k % 13), 32'h0, 1);
    $display("test bypass done");
    // matrix rounds, mostly moderate weights, every fourth one full range
    for (int n = 0; n < 8; n++) begin
      for (int i = 1; i < 13; i++)
        step(1, 0, addr_of(i), (n % 4 == 3) ? $urandom : ((i % 4 == 0) ?
             32'($urandom_range(0, 8191) - 4096) : 32'($urandom_range(0, 1536) - 512)), 1);
      step(1, 0, 12'h9c0, 32'h1, 1);
      for (int k = 0; k < 30; k++) step(0, 0, 12'h000, 32'h0, ($urandom % 8) != 0);
    end
    $display("test matrix done");
    // enable flipped every cycle under a back-to-back pixel stream
    for (int k = 0; k < 40; k++) step(1, 0, 12'h9c0, (k % 2) ? 32'hfffffffe : 32'h1, 1);
    $display("test toggle done");
    repeat (4) step(0, 0, 12'h000, 32'h0, 0);
    check(32'(pq.size() + rq.size()), 32'h0, "results left over");
    report_and_stop();
  end
endmodule
